// [src/async_serial_port.sv]
/*
  full-duplex 8/9-bit asynchronous serial port with apb register access.
  assumes: apb master on sys_clk_i, serial input from another clock domain,
  timer clocked from the core clock whenever its run bit is set.
  limitations a user must know:
  - a data write while the transmitter is busy is dropped without a flag.
  - an overrunning frame is dropped; the buffer keeps the older byte.
  - the bit period is 2*(256-reload) enabled clocks; reload must leave the
    receiver at least a few clocks between its half-bit ticks.
  - ce_i low freezes every register, the apb answer included.
*/
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module async_serial_port (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        serial_in_pin_i,
   output logic             serial_out_pin_o,
   output logic             irq_o
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   // apb      : registered answer, so every bus output is a flip-flop
   // ctrl     : serial_control_reg, flags included
   // reload   : timer_reload_value shared by both baud timers
   // tx_tmr   : timer_low_counter, drives the transmit bit clock
   // rx_tmr   : hidden receive copy, realigned at a start edge seen while idle with the receiver enabled
   // tx_div   : halves the transmit overflow stream
   // rx_div   : halves the receive stream, phase set for mid-bit ticks
   // tx_sh    : frame being sent, start bit in bit 0
   // rx_sync  : two synchroniser stages plus one edge-detect stage
   // rx_sh    : samples gathered so far, newest at the top
   // rx_buf   : buffered byte that software reads
   typedef struct packed {
      serial_port_pkg::apb_resp_type apb;
      logic [7:0]                    ctrl;
      logic [7:0]                    reload;
      logic                          tmr_run;
      logic                          irq_en;
      logic                          irq;
      logic [7:0]                    tx_tmr;
      logic                          tx_div;
      logic [7:0]                    rx_tmr;
      logic                          rx_div;
      serial_port_pkg::tx_state_type tx_st;
      logic [10:0]                   tx_sh;
      logic [3:0]                    tx_cnt;
      logic                          tx_pin;
      logic [2:0]                    rx_sync;
      serial_port_pkg::rx_state_type rx_st;
      logic [9:0]                    rx_sh;
      logic [3:0]                    rx_cnt;
      logic [7:0]                    rx_buf;
   } state_type;

   state_type q;
   state_type d;

   logic acc;
   logic wr;
   logic hit_ctrl;
   logic hit_data;
   logic hit_tmr;
   logic tx_ovf;
   logic rx_ovf;
   logic tx_tick;
   logic rx_tick;
   logic start_edge;
   logic rx_line;
   logic nine;
   logic stop_bit;
   logic ninth_in;
   logic accept;
   logic [3:0] tx_last;
   logic [3:0] rx_last;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      d = q;
      acc = psel_i & penable_i & q.apb.pready;
      wr = acc & pwrite_i;
      hit_ctrl = (paddr_i == serial_port_pkg::CTRL_OFFSET);
      hit_data = (paddr_i == serial_port_pkg::DATA_OFFSET);
      hit_tmr = (paddr_i == serial_port_pkg::TIMER_OFFSET);
      nine = q.ctrl[serial_port_pkg::FRAME_SEL_BIT];
      rx_line = q.rx_sync[1];
      stop_bit = 1'b0;
      ninth_in = 1'b0;
      accept = 1'b0;
      tx_last = serial_port_pkg::BITS_8BIT;
      rx_last = serial_port_pkg::STOP_8BIT;

      // ------------------------------------------------------------------
      // apb slave
      // ------------------------------------------------------------------
      // answer one cycle after setup; read data is captured at setup so
      // it stands unchanged through the access phase
      d.apb.pready = 1'b0;
      if (psel_i & ~penable_i) begin
         d.apb.pready = 1'b1;
         d.apb.pslverr = ~(hit_ctrl | hit_data | hit_tmr);
         d.apb.prdata = 32'h0000_0000;
         if (hit_ctrl) begin
            d.apb.prdata[7:0] = q.ctrl;
            d.apb.prdata[serial_port_pkg::UNUSED_BIT] = 1'b1;
         end
         if (hit_data) begin
            d.apb.prdata[7:0] = q.rx_buf;
         end
         if (hit_tmr) begin
            d.apb.prdata[7:0] = q.reload;
            d.apb.prdata[serial_port_pkg::TMR_RUN_BIT] = q.tmr_run;
            d.apb.prdata[serial_port_pkg::IRQ_EN_BIT] = q.irq_en;
         end
      end else if (acc) begin
         d.apb.pslverr = 1'b0;
      end

      // ------------------------------------------------------------------
      // register writes
      // ------------------------------------------------------------------
      // software writes every control bit; hardware flag sets further
      // down overwrite d.ctrl, so a set in the same cycle wins
      if (wr & hit_ctrl) begin
         d.ctrl = pwdata_i[7:0];
      end
      if (wr & hit_tmr) begin
         d.reload = pwdata_i[7:0];
         d.tmr_run = pwdata_i[serial_port_pkg::TMR_RUN_BIT];
         d.irq_en = pwdata_i[serial_port_pkg::IRQ_EN_BIT];
      end

      // ------------------------------------------------------------------
      // baud timers
      // ------------------------------------------------------------------
      // 8-bit auto-reload, overflow halved; the receive divider ticks on
      // its first overflow after a realign, half a bit after the start edge
      tx_ovf = q.tmr_run & (q.tx_tmr == serial_port_pkg::TIMER_TOP);
      rx_ovf = q.tmr_run & (q.rx_tmr == serial_port_pkg::TIMER_TOP);
      tx_tick = tx_ovf & q.tx_div;
      rx_tick = rx_ovf & ~q.rx_div;
      if (q.tmr_run) begin
         d.tx_tmr = tx_ovf ? q.reload : q.tx_tmr + 8'h01;
         d.rx_tmr = rx_ovf ? q.reload : q.rx_tmr + 8'h01;
      end
      if (tx_ovf) begin
         d.tx_div = ~q.tx_div;
      end
      if (rx_ovf) begin
         d.rx_div = ~q.rx_div;
      end

      // ------------------------------------------------------------------
      // transmitter
      // ------------------------------------------------------------------
      // tx_sh holds start, data, ninth and stop from bit 0 upward; each
      // tick puts bit 0 on the pin, so count n shows frame bit n
      case (q.tx_st)
         serial_port_pkg::TX_IDLE: begin
            d.tx_pin = 1'b1;
            if (wr & hit_data) begin
               d.tx_sh = {1'b1, q.ctrl[serial_port_pkg::TX_NINTH_BIT], pwdata_i[7:0], 1'b0};
               if (!nine) begin
                  d.tx_sh[9] = 1'b1;
               end
               d.tx_cnt = 4'h0;
               d.tx_st = serial_port_pkg::TX_SEND;
            end
         end
         serial_port_pkg::TX_SEND: begin
            if (tx_tick) begin
               tx_last = nine ? serial_port_pkg::BITS_9BIT
                              : serial_port_pkg::BITS_8BIT;
               d.tx_pin = q.tx_sh[0];
               d.tx_sh = {1'b1, q.tx_sh[10:1]};
               d.tx_cnt = q.tx_cnt + 4'h1;
               if (q.tx_cnt == tx_last) begin
                  d.ctrl[serial_port_pkg::TX_DONE_BIT] = 1'b1;
               end
               if (q.tx_cnt > tx_last) begin
                  d.tx_st = serial_port_pkg::TX_IDLE;
               end
            end
         end
         default: begin
            d.tx_st = serial_port_pkg::TX_IDLE;
            d.tx_pin = 1'b1;
         end
      endcase

      // ------------------------------------------------------------------
      // receiver
      // ------------------------------------------------------------------
      // sample 0 is the start bit; at the stop sample rx_sh holds every
      // earlier sample, start bit lowest, so the data sit just above it
      d.rx_sync = {q.rx_sync[1:0], serial_in_pin_i};
      start_edge = q.rx_sync[2] & ~rx_line;
      rx_last = nine ? serial_port_pkg::STOP_9BIT : serial_port_pkg::STOP_8BIT;
      case (q.rx_st)
         serial_port_pkg::RX_IDLE: begin
            if (start_edge & q.ctrl[serial_port_pkg::RX_EN_BIT]) begin
               d.rx_tmr = q.reload;
               d.rx_div = 1'b0;
               d.rx_cnt = 4'h0;
               d.rx_st = serial_port_pkg::RX_BITS;
            end
         end
         serial_port_pkg::RX_BITS: begin
            if (!q.ctrl[serial_port_pkg::RX_EN_BIT]) begin
               d.rx_st = serial_port_pkg::RX_IDLE;
            end else if (rx_tick) begin
               d.rx_cnt = q.rx_cnt + 4'h1;
               d.rx_sh = {rx_line, q.rx_sh[9:1]};
               if ((q.rx_cnt == 4'h0) & rx_line) begin
                  d.rx_st = serial_port_pkg::RX_IDLE;
               end else if (q.rx_cnt == rx_last) begin
                  d.rx_st = serial_port_pkg::RX_IDLE;
                  stop_bit = rx_line;
                  ninth_in = q.rx_sh[9];
                  if (nine) begin
                     accept = ~q.ctrl[serial_port_pkg::RX_DONE_BIT] &
                        (~q.ctrl[serial_port_pkg::MPROC_BIT] | ninth_in);
                  end else begin
                     accept = ~q.ctrl[serial_port_pkg::RX_DONE_BIT] &
                        (~q.ctrl[serial_port_pkg::MPROC_BIT] | stop_bit);
                  end
                  if (accept) begin
                     d.rx_buf = nine ? q.rx_sh[8:1] : q.rx_sh[9:2];
                     d.ctrl[serial_port_pkg::RX_NINTH_BIT] = nine ? ninth_in : stop_bit;
                     d.ctrl[serial_port_pkg::RX_DONE_BIT] = 1'b1;
                  end
               end
            end
         end
         default: begin
            d.rx_st = serial_port_pkg::RX_IDLE;
         end
      endcase

      // ------------------------------------------------------------------
      // interrupt
      // ------------------------------------------------------------------
      // level of enabled flags, flags cleared by software only
      d.irq = q.irq_en & (d.ctrl[serial_port_pkg::TX_DONE_BIT] |
                          d.ctrl[serial_port_pkg::RX_DONE_BIT]);
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q.apb <= '0;
         q.ctrl <= serial_port_pkg::CTRL_RESET;
         q.reload <= serial_port_pkg::RELOAD_RESET;
         q.tmr_run <= 1'b0;
         q.irq_en <= 1'b0;
         q.irq <= 1'b0;
         q.tx_tmr <= serial_port_pkg::RELOAD_RESET;
         q.tx_div <= 1'b0;
         q.rx_tmr <= serial_port_pkg::RELOAD_RESET;
         q.rx_div <= 1'b0;
         q.tx_st <= serial_port_pkg::TX_IDLE;
         q.tx_sh <= '1;
         q.tx_cnt <= 4'h0;
         q.tx_pin <= 1'b1;
         q.rx_sync <= 3'h7;
         q.rx_st <= serial_port_pkg::RX_IDLE;
         q.rx_sh <= '0;
         q.rx_cnt <= 4'h0;
         q.rx_buf <= 8'h00;
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign prdata_o = q.apb.prdata;
   assign pready_o = q.apb.pready;
   assign pslverr_o = q.apb.pslverr;
   assign serial_out_pin_o = q.tx_pin;
   assign irq_o = q.irq;

endmodule

// [inc/serial_port_pkg.sv]
/*
  constants, field positions and state types for the asynchronous serial port.
  assumes a 32-bit apb register bus and one system clock.
*/
package serial_port_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [7:0] CTRL_OFFSET  = 8'h00;
   localparam logic [7:0] DATA_OFFSET  = 8'h04;
   localparam logic [7:0] TIMER_OFFSET = 8'h08;

   // serial_control_reg fields
   localparam int FRAME_SEL_BIT = 7;
   localparam int UNUSED_BIT    = 6;
   localparam int MPROC_BIT     = 5;
   localparam int RX_EN_BIT     = 4;
   localparam int TX_NINTH_BIT  = 3;
   localparam int RX_NINTH_BIT  = 2;
   localparam int TX_DONE_BIT   = 1;
   localparam int RX_DONE_BIT   = 0;
   localparam logic [7:0] CTRL_RESET = 8'h40;

   // timer register fields
   localparam int TMR_RUN_BIT = 8;
   localparam int IRQ_EN_BIT  = 9;
   localparam logic [7:0] RELOAD_RESET = 8'h00;
   localparam logic [7:0] TIMER_TOP    = 8'hff;

   // frame shape
   localparam logic [3:0] BITS_8BIT  = 4'h9;
   localparam logic [3:0] BITS_9BIT  = 4'ha;
   localparam logic [3:0] DATA_BITS  = 4'h8;
   localparam logic [3:0] STOP_8BIT  = 4'h9;
   localparam logic [3:0] STOP_9BIT  = 4'ha;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SEND = 2'b10
   } tx_state_type;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b01,
      RX_BITS = 2'b10
   } rx_state_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_resp_type;

endpackage

// [verif/async_serial_port_sva.sv]
/* port checker for the serial port: apb answer timing, line framing, flag clearing.
   assumes bind onto async_serial_port and a reload giving bits of 16 clocks. */
`timescale 1ns/1ps
module async_serial_port_sva (
   input wire logic        sys_clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        serial_in_pin_i,
   input wire logic        serial_out_pin_o,
   input wire logic        irq_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   logic setup;
   logic mapped;
   logic wr_done;
   assign setup   = psel_i && !penable_i && ce_i;
   assign mapped  = paddr_i inside {serial_port_pkg::CTRL_OFFSET, serial_port_pkg::DATA_OFFSET,
                                    serial_port_pkg::TIMER_OFFSET};
   assign wr_done = psel_i && penable_i && pwrite_i && pready_o;
   setup_ready_a: assert property (setup |=> pready_o) else $error("no answer after setup");
   ready_pulse_a: assert property (pready_o && ce_i |=> !pready_o) else $error("pready held");
   ready_access_a: assert property (pready_o |-> psel_i && penable_i) else $error("stray pready");
   unmapped_err_a: assert property (setup && !mapped |=>
      pslverr_o && prdata_o == 32'h0000_0000) else $error("unmapped access not refused");
   ctrl_fixed_a: assert property (setup && !pwrite_i &&
      paddr_i == serial_port_pkg::CTRL_OFFSET |=> prdata_o[6] && prdata_o[31:8] == 24'h00_0000)
      else $error("control read bad");
   start_bit_a: assert property ($fell(serial_out_pin_o) |-> (!serial_out_pin_o) [*8])
      else $error("start bit too short");
   bit_hold_a: assert property ($changed(serial_out_pin_o) |=>
      $stable(serial_out_pin_o) [*8]) else $error("output bit too short");
   sw_clear_a: assert property ($fell(irq_o) |-> $past(wr_done) || $past(wr_done, 2))
      else $error("flag cleared without software");
   unmapped_c: cover property (setup && !mapped);
   irq_c: cover property ($rose(irq_o));
   frame_c: cover property ($fell(serial_out_pin_o));
endmodule
bind async_serial_port async_serial_port_sva chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
   .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(serial_out_pin_o), .irq_o(irq_o));

// [verif/serial_peer.sv]
/* remote uart on the serial lines: sends and decodes 8-bit and 9-bit frames.
   assumes both ends use a bit time of BIT clocks of the shared clock. */
`timescale 1ns/1ps
module serial_peer #(parameter int BIT = 16) (
   input  wire logic clk_i,
   input  wire logic line_i,
   output logic      line_o
);
   initial line_o = 1'b1;
   task automatic send(input logic [7:0] d, input logic nine, input logic ninth, input logic stop);
      logic [10:0] f;
      f = nine ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge clk_i);
         line_o <= f[i];
         repeat (BIT - 1) @(posedge clk_i);
      end
      @(posedge clk_i);
      line_o <= 1'b1;
   endtask
   task automatic recv(input logic nine, output logic [7:0] d, output logic ninth, output logic ok);
      int n;
      n = 0;
      ninth = 1'b0;
      while (line_i !== 1'b0 && n < 4000) begin
         @(posedge clk_i);
         n++;
      end
      ok = (n < 4000);
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge clk_i);
         d[i] = line_i;
      end
      if (nine) begin
         repeat (BIT) @(posedge clk_i);
         ninth = line_i;
      end
      repeat (BIT) @(posedge clk_i);
      ok = ok && (line_i === 1'b1);
   endtask
endmodule

// [verif/tb.sv]
/* self-checking bench: apb master, random tx and rx frames through a remote peer.
   assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module tb;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, d, dl;
   logic [31:0] pwdata = 32'h0000_0000, prdata, r, rd;
   logic        pready, pslverr, rx_line, tx_line, irq, er, n9, ok, e;
   logic [9:0]  rxc [7] = '{{8'h10, 2'b01}, {8'h00, 2'b01}, {8'h30, 2'b00}, {8'h30, 2'b01},
                           {8'hb0, 2'b00}, {8'h90, 2'b10}, {8'hb0, 2'b10}};
   logic [7:0]  txc [3] = '{8'h00, 8'h88, 8'h80};
   int          failures = 0, n_tests = 0;
   integer      seed = 60;
   always #2.5 clk = ~clk;
   async_serial_port DUT (.sys_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .serial_in_pin_i(rx_line),
      .serial_out_pin_o(tx_line), .irq_o(irq));
   serial_peer #(.BIT(16)) peer (.clk_i(clk), .line_i(tx_line), .line_o(rx_line));
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         failures++;
         close_out();
      end
   endtask
   // stop bit decides in 8-bit mode, ninth bit in 9-bit mode
   function automatic logic accepts(logic [7:0] c, logic ninth, logic stop);
      return c[4] && (!c[5] || (c[7] ? ninth : stop));
   endfunction
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, 8'h00, 32'h0);
      check(rd, 32'h0000_0040);
      apb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0000_0000);
      apb(1'b0, 8'h0c, 32'h0);
      check({er, rd}, {1'b1, 32'h0000_0000});
      apb(1'b1, 8'h08, 32'h0000_03f8);
      foreach (txc[i]) begin
         d = 8'($random(seed));
         r = $random(seed);
         apb(1'b1, 8'h00, {24'h0, txc[i]});
         fork
            peer.recv(txc[i][7], dl, n9, ok);
            apb(1'b1, 8'h04, {r[23:0], d});
         join
         // the stop bit is still going out; a data write now would be dropped
         repeat (32) @(posedge clk);
         check({ok, dl}, {1'b1, d});
         if (txc[i][7]) check(n9, txc[i][3]);
         apb(1'b0, 8'h00, 32'h0);
         check({irq, rd[1]}, 2'b11);
      end
      foreach (rxc[i]) begin
         d = 8'($random(seed));
         apb(1'b1, 8'h00, {24'h0, rxc[i][9:2]});
         peer.send(d, rxc[i][9], rxc[i][1], rxc[i][0]);
         repeat (4) @(posedge clk);
         apb(1'b0, 8'h00, 32'h0);
         e = accepts(rxc[i][9:2], rxc[i][1], rxc[i][0]);
         check({irq, rd[0]}, {e, e});
         if (e) check(rd[2], rxc[i][9] ? rxc[i][1] : rxc[i][0]);
         apb(1'b0, 8'h04, 32'h0);
         if (e) check(rd, {24'h0, d});
         dl = d;
      end
      peer.send(8'($random(seed)), 1'b1, 1'b1, 1'b1);
      repeat (4) @(posedge clk);
      apb(1'b0, 8'h04, 32'h0);
      check(rd, {24'h0, dl});
      apb(1'b1, 8'h00, 32'h0);
      @(posedge clk);
      check(irq, 1'b0);
      close_out();
   end
endmodule
